//--- include/socr_pkg.sv
// constants for the synthesizer output configuration register bank
package socr_pkg;

  // -----------------------------------------------------------------
  // register slots (storage index)
  // -----------------------------------------------------------------
  localparam int SOCR_NREG = 23;
  localparam logic [4:0] SOCR_S_SHIFT = 5'h00;
  localparam logic [4:0] SOCR_S_RATE = 5'h01;
  localparam logic [4:0] SOCR_S_SHAPE = 5'h02;
  localparam logic [4:0] SOCR_S_S1EN = 5'h03;
  localparam logic [4:0] SOCR_S_S1RUN = 5'h04;
  localparam logic [4:0] SOCR_S_MLOW = 5'h05;
  localparam logic [4:0] SOCR_S_MHIGH = 5'h06;
  localparam logic [4:0] SOCR_S_DIV = 5'h07;
  localparam logic [4:0] SOCR_S_AEN = 5'h08;
  localparam logic [4:0] SOCR_S_ARUN = 5'h09;
  localparam logic [4:0] SOCR_S_AFREQ = 5'h0a;
  localparam logic [4:0] SOCR_S_TRIM = 5'h0b;
  localparam logic [4:0] SOCR_S_PAGE = 5'h0c;
  localparam logic [4:0] SOCR_S_RMA = 5'h0d;
  localparam logic [4:0] SOCR_S_RMB = 5'h0e;
  localparam logic [4:0] SOCR_S_CALO = 5'h0f;
  localparam logic [4:0] SOCR_S_CAHI = 5'h10;
  localparam logic [4:0] SOCR_S_SCMLO = 5'h11;
  localparam logic [4:0] SOCR_S_SCMHI = 5'h12;
  localparam logic [4:0] SOCR_S_CFL0 = 5'h13;
  localparam logic [4:0] SOCR_S_CFL1 = 5'h14;
  localparam logic [4:0] SOCR_S_CFH0 = 5'h15;
  localparam logic [4:0] SOCR_S_CFH1 = 5'h16;
  localparam logic [4:0] SOCR_S_NONE = 5'h1f;

  // -----------------------------------------------------------------
  // register indices; byte address is four times the index
  // -----------------------------------------------------------------
  localparam logic [9:0] SOCR_IDX_SHIFT = 10'h042;
  localparam logic [9:0] SOCR_IDX_RATE = 10'h043;
  localparam logic [9:0] SOCR_IDX_SHAPE = 10'h044;
  localparam logic [9:0] SOCR_IDX_S1EN = 10'h048;
  localparam logic [9:0] SOCR_IDX_S1RUN = 10'h049;
  localparam logic [9:0] SOCR_IDX_MLOW = 10'h04a;
  localparam logic [9:0] SOCR_IDX_MHIGH = 10'h04b;
  localparam logic [9:0] SOCR_IDX_DIV = 10'h04d;
  localparam logic [9:0] SOCR_IDX_AEN = 10'h050;
  localparam logic [9:0] SOCR_IDX_ARUN = 10'h051;
  localparam logic [9:0] SOCR_IDX_AFREQ = 10'h052;
  localparam logic [9:0] SOCR_IDX_TRIM = 10'h063;
  localparam logic [9:0] SOCR_IDX_PAGE = 10'h064;
  localparam logic [9:0] SOCR_IDX_RMA = 10'h065;
  localparam logic [9:0] SOCR_IDX_RMB = 10'h066;
  localparam logic [9:0] SOCR_IDX_CALO = 10'h067;
  localparam logic [9:0] SOCR_IDX_CAHI = 10'h068;
  localparam logic [9:0] SOCR_IDX_SCMLO = 10'h069;
  localparam logic [9:0] SOCR_IDX_SCMHI = 10'h06a;
  localparam logic [9:0] SOCR_IDX_CFL0 = 10'h06b;
  localparam logic [9:0] SOCR_IDX_CFL1 = 10'h06c;
  localparam logic [9:0] SOCR_IDX_CFH0 = 10'h06d;
  localparam logic [9:0] SOCR_IDX_CFH1 = 10'h06e;

  // -----------------------------------------------------------------
  // reset values and writable-bit masks, by slot
  // -----------------------------------------------------------------
  localparam logic [7:0] SOCR_RST [SOCR_NREG] = '{
    8'h00, 8'h05, 8'h31, 8'h81, 8'h01, 8'hc8, 8'h10, 8'h3f,
    8'h8f, 8'h0f, 8'h42, 8'hf5, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] SOCR_MSK [SOCR_NREG] = '{
    8'h3f, 8'h07, 8'hf3, 8'hc3, 8'h03, 8'hff, 8'h3f, 8'h3f,
    8'hc3, 8'h73, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'h3f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};

  // -----------------------------------------------------------------
  // field positions and codes
  // -----------------------------------------------------------------
  localparam int SOCR_B_OUT0 = 0;
  localparam int SOCR_B_OUT1 = 1;
  localparam int SOCR_B_STYLE = 0;
  localparam int SOCR_B_EDGE = 1;
  localparam int SOCR_B_SPEED0 = 4;
  localparam int SOCR_B_SPEED1 = 5;
  localparam int SOCR_B_SRC = 6;
  localparam int SOCR_B_FAMILY = 6;
  localparam int SOCR_B_PWR = 7;
  localparam int SOCR_B_POL = 7;
  localparam logic [2:0] SOCR_WIDTH_CLK = 3'h7;

endpackage

//--- core/socr_regs.sv
// apb register bank for synthesizer output and reference configuration
`timescale 1ns/10ps
`default_nettype none

module socr_regs
  import socr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [5:0] pulse_coarse_shift,
  output logic [2:0] synth0_pulse1_rate_code,
  output logic pulse_clock_style,
  output logic pulse_edge_select,
  output logic [2:0] pulse_width_code,
  output logic pulse_width_from_clock,
  output logic pulse_polarity_select,
  output logic synth1_power_on,
  output logic synth1_loop_select,
  output logic synth1_out0_drive,
  output logic synth1_out1_drive,
  output logic synth1_out0_toggle,
  output logic synth1_out1_toggle,
  output logic [13:0] synth1_mult,
  output logic [5:0] synth1_pow2_exponent,
  output logic analog_power_on,
  output logic analog_loop_select,
  output logic analog_out0_drive,
  output logic analog_out1_drive,
  output logic analog_out0_toggle,
  output logic analog_out1_toggle,
  output logic out0_speed_group,
  output logic out1_speed_group,
  output logic analog_ethernet_family,
  output logic [3:0] analog_out0_freq_code,
  output logic [3:0] analog_out1_freq_code,
  output logic [7:0] feedback_trim_value,
  output logic [7:0] ext_page_select,
  output logic [15:0] reference_rate_mode,
  output logic [13:0] custom_a_rate,
  output logic [7:0] custom_a_cycle_floor,
  output logic [7:0] custom_a_cycle_ceiling,
  output logic [15:0] custom_a_freq_floor,
  output logic [15:0] custom_a_freq_ceiling
);

  // -----------------------------------------------------------------
  // address decode
  // -----------------------------------------------------------------

  // word index to storage slot; unknown words give the none slot
  function automatic logic [4:0] socr_slot(input logic [9:0] widx);
    logic [4:0] s;
    s = SOCR_S_NONE;
    case (widx)
      SOCR_IDX_SHIFT: s = SOCR_S_SHIFT;
      SOCR_IDX_RATE: s = SOCR_S_RATE;
      SOCR_IDX_SHAPE: s = SOCR_S_SHAPE;
      SOCR_IDX_S1EN: s = SOCR_S_S1EN;
      SOCR_IDX_S1RUN: s = SOCR_S_S1RUN;
      SOCR_IDX_MLOW: s = SOCR_S_MLOW;
      SOCR_IDX_MHIGH: s = SOCR_S_MHIGH;
      SOCR_IDX_DIV: s = SOCR_S_DIV;
      SOCR_IDX_AEN: s = SOCR_S_AEN;
      SOCR_IDX_ARUN: s = SOCR_S_ARUN;
      SOCR_IDX_AFREQ: s = SOCR_S_AFREQ;
      SOCR_IDX_TRIM: s = SOCR_S_TRIM;
      SOCR_IDX_PAGE: s = SOCR_S_PAGE;
      SOCR_IDX_RMA: s = SOCR_S_RMA;
      SOCR_IDX_RMB: s = SOCR_S_RMB;
      SOCR_IDX_CALO: s = SOCR_S_CALO;
      SOCR_IDX_CAHI: s = SOCR_S_CAHI;
      SOCR_IDX_SCMLO: s = SOCR_S_SCMLO;
      SOCR_IDX_SCMHI: s = SOCR_S_SCMHI;
      SOCR_IDX_CFL0: s = SOCR_S_CFL0;
      SOCR_IDX_CFL1: s = SOCR_S_CFL1;
      SOCR_IDX_CFH0: s = SOCR_S_CFH0;
      SOCR_IDX_CFH1: s = SOCR_S_CFH1;
      default: s = SOCR_S_NONE;
    endcase
    return s;
  endfunction

  logic [7:0] regs [SOCR_NREG];
  wire logic [4:0] acc_slot;
  wire logic hit;
  wire logic access_wait;
  wire logic access_done;
  wire logic wr_fire;
  wire logic [7:0] rd_byte;

  // one wait state: the flopped ready answers the second access cycle
  assign acc_slot = socr_slot(paddr[11:2]);
  assign hit = (paddr[1:0] == 2'h0) && (acc_slot != SOCR_S_NONE);
  assign access_wait = psel && penable && !pready;
  assign access_done = psel && penable && pready;
  assign wr_fire = access_done && pwrite && hit && pstrb[0];
  assign rd_byte = hit ? regs[acc_slot] : 8'h00;

  // -----------------------------------------------------------------
  // bus answer
  // -----------------------------------------------------------------

  // read data is latched a cycle early so it stands with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access_wait;
      pslverr <= access_wait && !hit;
      prdata <= access_wait ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // -----------------------------------------------------------------
  // storage
  // -----------------------------------------------------------------

  // reserved bits are masked so they never leave their default
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < SOCR_NREG; i++) begin
        regs[i] <= SOCR_RST[i];
      end
    end else begin
      for (int i = 0; i < SOCR_NREG; i++) begin
        if (wr_fire && acc_slot == 5'(i)) begin
          regs[i] <= (pwdata[7:0] & SOCR_MSK[i]) | (regs[i] & ~SOCR_MSK[i]);
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // field decode
  // -----------------------------------------------------------------

  // synth0 second frame pulse fields
  wire logic [7:0] shape = regs[SOCR_S_SHAPE];
  wire logic [5:0] f_shift = regs[SOCR_S_SHIFT][5:0];
  wire logic [2:0] f_rate = regs[SOCR_S_RATE][2:0];
  wire logic [2:0] f_width = shape[SOCR_B_POL-1:SOCR_B_SPEED0];
  wire logic f_from_clk = (f_width == SOCR_WIDTH_CLK);

  // synth1: drive and toggle outputs only live while the synthesizer is powered
  wire logic [7:0] s1en = regs[SOCR_S_S1EN];
  wire logic [7:0] s1run = regs[SOCR_S_S1RUN];
  wire logic s1_pwr = s1en[SOCR_B_PWR];
  wire logic s1_drv0 = s1_pwr && s1en[SOCR_B_OUT0];
  wire logic s1_drv1 = s1_pwr && s1en[SOCR_B_OUT1];
  wire logic s1_tog0 = s1_pwr && s1run[SOCR_B_OUT0];
  wire logic s1_tog1 = s1_pwr && s1run[SOCR_B_OUT1];
  wire logic [13:0] s1_mult = {regs[SOCR_S_MHIGH][5:0], regs[SOCR_S_MLOW]};

  // analog loop: same gating as synth1
  wire logic [7:0] aen = regs[SOCR_S_AEN];
  wire logic [7:0] arun = regs[SOCR_S_ARUN];
  wire logic a_pwr = aen[SOCR_B_PWR];
  wire logic a_drv0 = a_pwr && aen[SOCR_B_OUT0];
  wire logic a_drv1 = a_pwr && aen[SOCR_B_OUT1];
  wire logic a_tog0 = a_pwr && arun[SOCR_B_OUT0];
  wire logic a_tog1 = a_pwr && arun[SOCR_B_OUT1];

  // custom a reference figures
  wire logic [13:0] ca_rate = {regs[SOCR_S_CAHI][5:0], regs[SOCR_S_CALO]};
  wire logic [15:0] ca_floor = {regs[SOCR_S_CFL1], regs[SOCR_S_CFL0]};
  wire logic [15:0] ca_ceil = {regs[SOCR_S_CFH1], regs[SOCR_S_CFH0]};

  // -----------------------------------------------------------------
  // output flops
  // -----------------------------------------------------------------

  // outputs lag the register by one cycle so every port is a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_coarse_shift <= 6'h00;
      synth0_pulse1_rate_code <= 3'h0;
      pulse_clock_style <= 1'b0;
      pulse_edge_select <= 1'b0;
      pulse_width_code <= 3'h0;
      pulse_width_from_clock <= 1'b0;
      pulse_polarity_select <= 1'b0;
      synth1_power_on <= 1'b0;
      synth1_loop_select <= 1'b0;
      synth1_out0_drive <= 1'b0;
      synth1_out1_drive <= 1'b0;
      synth1_out0_toggle <= 1'b0;
      synth1_out1_toggle <= 1'b0;
      synth1_mult <= 14'h0000;
      synth1_pow2_exponent <= 6'h00;
      analog_power_on <= 1'b0;
      analog_loop_select <= 1'b0;
      analog_out0_drive <= 1'b0;
      analog_out1_drive <= 1'b0;
      analog_out0_toggle <= 1'b0;
      analog_out1_toggle <= 1'b0;
      out0_speed_group <= 1'b0;
      out1_speed_group <= 1'b0;
      analog_ethernet_family <= 1'b0;
      analog_out0_freq_code <= 4'h0;
      analog_out1_freq_code <= 4'h0;
      feedback_trim_value <= 8'h00;
      ext_page_select <= 8'h00;
      reference_rate_mode <= 16'h0000;
      custom_a_rate <= 14'h0000;
      custom_a_cycle_floor <= 8'h00;
      custom_a_cycle_ceiling <= 8'h00;
      custom_a_freq_floor <= 16'h0000;
      custom_a_freq_ceiling <= 16'h0000;
    end else begin
      pulse_coarse_shift <= f_shift;
      synth0_pulse1_rate_code <= f_rate;
      pulse_clock_style <= shape[SOCR_B_STYLE];
      pulse_edge_select <= shape[SOCR_B_EDGE];
      pulse_width_code <= f_width;
      pulse_width_from_clock <= f_from_clk;
      pulse_polarity_select <= shape[SOCR_B_POL];
      synth1_power_on <= s1_pwr;
      synth1_loop_select <= s1en[SOCR_B_SRC];
      synth1_out0_drive <= s1_drv0;
      synth1_out1_drive <= s1_drv1;
      synth1_out0_toggle <= s1_tog0;
      synth1_out1_toggle <= s1_tog1;
      synth1_mult <= s1_mult;
      synth1_pow2_exponent <= regs[SOCR_S_DIV][5:0];
      analog_power_on <= a_pwr;
      analog_loop_select <= aen[SOCR_B_SRC];
      analog_out0_drive <= a_drv0;
      analog_out1_drive <= a_drv1;
      analog_out0_toggle <= a_tog0;
      analog_out1_toggle <= a_tog1;
      out0_speed_group <= arun[SOCR_B_SPEED0];
      out1_speed_group <= arun[SOCR_B_SPEED1];
      analog_ethernet_family <= arun[SOCR_B_FAMILY];
      analog_out0_freq_code <= regs[SOCR_S_AFREQ][3:0];
      analog_out1_freq_code <= regs[SOCR_S_AFREQ][7:4];
      feedback_trim_value <= regs[SOCR_S_TRIM];
      ext_page_select <= regs[SOCR_S_PAGE];
      reference_rate_mode <= {regs[SOCR_S_RMB], regs[SOCR_S_RMA]};
      custom_a_rate <= ca_rate;
      custom_a_cycle_floor <= regs[SOCR_S_SCMLO];
      custom_a_cycle_ceiling <= regs[SOCR_S_SCMHI];
      custom_a_freq_floor <= ca_floor;
      custom_a_freq_ceiling <= ca_ceil;
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------

  // a write shows at the synth1 output two edges later
  a_s1_drive_path: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_fire && acc_slot == SOCR_S_S1EN
    |=> ##1 synth1_out0_drive == ($past(pwdata[0], 2) && $past(pwdata[7], 2))
  ) else $error("synth1 drive does not follow enable write");

  a_s1_power_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    !synth1_power_on |-> !synth1_out0_toggle && !synth1_out1_toggle
      && !synth1_out0_drive && !synth1_out1_drive
  ) else $error("synth1 output active while powered off");

  a_an_power_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    !analog_power_on |-> !analog_out0_drive && !analog_out1_drive
      && !analog_out0_toggle && !analog_out1_toggle
  ) else $error("analog output active while powered off");

  a_an_gate_path: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_fire && acc_slot == SOCR_S_ARUN && !pwdata[1]
    |=> ##1 !analog_out1_toggle
  ) else $error("analog output 1 not held low after run clear");

  a_width_clock: assert property (
    @(posedge pclk) disable iff (!presetn)
    pulse_width_from_clock == (pulse_width_code == SOCR_WIDTH_CLK)
  ) else $error("clock-follow width flag disagrees with code");

  a_mult_join: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_fire && acc_slot == SOCR_S_MHIGH
    |=> ##1 synth1_mult[13:8] == $past(pwdata[5:0], 2)
  ) else $error("synth1 multiplier high part lost");

  a_reserved_kept: assert property (
    @(posedge pclk) disable iff (!presetn)
    regs[SOCR_S_RATE][7:3] == 5'h00 && regs[SOCR_S_AEN][3:2] == 2'h3
      && regs[SOCR_S_ARUN][7] == 1'b0 && regs[SOCR_S_SHAPE][3:2] == 2'h0
  ) else $error("reserved bits left their default");

  a_read_back: assert property (
    @(posedge pclk) disable iff (!presetn)
    access_wait && !pwrite && hit |=> pready && prdata[7:0] == $past(rd_byte)
      && prdata[31:8] == 24'h00_0000 && !pslverr
  ) else $error("read data wrong at ready");

  a_unmapped_err: assert property (
    @(posedge pclk) disable iff (!presetn)
    access_wait && !hit |=> pready && pslverr && prdata == 32'h0000_0000
  ) else $error("unmapped access not refused");

  a_mode_pack: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_fire && acc_slot == SOCR_S_RMB
    |=> ##1 reference_rate_mode[15:8] == $past(pwdata[7:0], 2)
  ) else $error("reference modes 4 to 7 not updated");

  a_trim_path: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_fire && acc_slot == SOCR_S_TRIM
    |=> ##1 feedback_trim_value == $past(pwdata[7:0], 2)
  ) else $error("feedback trim not updated");

  // ready is a single-cycle answer; a held ready would store a write twice
  a_ready_single: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready
  ) else $error("ready held for more than one cycle");

  // a write with the low byte lane off must leave storage alone
  a_lane_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    access_done && pwrite && !pstrb[0] && acc_slot == SOCR_S_TRIM
    |=> $stable(regs[SOCR_S_TRIM])
  ) else $error("write stored with byte lane off");

  a_page_path: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_fire && acc_slot == SOCR_S_PAGE
    |=> ##1 ext_page_select == $past(pwdata[7:0], 2)
  ) else $error("page select not updated");

endmodule

`default_nettype wire

//--- tb/test_socr_regs.sv
// self-checking apb bench for the synthesizer output configuration registers
`timescale 1ns/10ps
`default_nettype none
module test_socr_regs;
  // ---------------------------------------------------------------
  // signals, expected register image
  // ---------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [5:0] pulse_coarse_shift, synth1_pow2_exponent;
  logic [2:0] synth0_pulse1_rate_code, pulse_width_code;
  logic pulse_clock_style, pulse_edge_select, pulse_width_from_clock, pulse_polarity_select;
  logic synth1_power_on, synth1_loop_select, synth1_out0_drive, synth1_out1_drive;
  logic synth1_out0_toggle, synth1_out1_toggle, analog_power_on, analog_loop_select;
  logic analog_out0_drive, analog_out1_drive, analog_out0_toggle, analog_out1_toggle;
  logic out0_speed_group, out1_speed_group, analog_ethernet_family;
  logic [13:0] synth1_mult, custom_a_rate;
  logic [3:0] analog_out0_freq_code, analog_out1_freq_code;
  logic [7:0] feedback_trim_value, ext_page_select, custom_a_cycle_floor, custom_a_cycle_ceiling;
  logic [15:0] reference_rate_mode, custom_a_freq_floor, custom_a_freq_ceiling;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  // word indices, reset values and writable bits, in table order
  localparam logic [7:0] IDX [23] = '{8'h42, 8'h43, 8'h44, 8'h48, 8'h49, 8'h4a, 8'h4b,
    8'h4d, 8'h50, 8'h51, 8'h52, 8'h63, 8'h64, 8'h65, 8'h66, 8'h67, 8'h68, 8'h69, 8'h6a,
    8'h6b, 8'h6c, 8'h6d, 8'h6e};
  localparam logic [7:0] RST [23] = '{8'h00, 8'h05, 8'h31, 8'h81, 8'h01, 8'hc8, 8'h10,
    8'h3f, 8'h8f, 8'h0f, 8'h42, 8'hf5, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] MSK [23] = '{8'h3f, 8'h07, 8'hf3, 8'hc3, 8'h03, 8'hff, 8'h3f,
    8'h3f, 8'hc3, 8'h73, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff};
  logic [7:0] mem [23];

  socr_regs i_socr_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .pulse_coarse_shift, .synth0_pulse1_rate_code,
    .pulse_clock_style, .pulse_edge_select, .pulse_width_code, .pulse_width_from_clock,
    .pulse_polarity_select, .synth1_power_on, .synth1_loop_select, .synth1_out0_drive,
    .synth1_out1_drive, .synth1_out0_toggle, .synth1_out1_toggle, .synth1_mult,
    .synth1_pow2_exponent, .analog_power_on, .analog_loop_select, .analog_out0_drive,
    .analog_out1_drive, .analog_out0_toggle, .analog_out1_toggle, .out0_speed_group,
    .out1_speed_group, .analog_ethernet_family, .analog_out0_freq_code,
    .analog_out1_freq_code, .feedback_trim_value, .ext_page_select, .reference_rate_mode,
    .custom_a_rate, .custom_a_cycle_floor, .custom_a_cycle_ceiling, .custom_a_freq_floor,
    .custom_a_freq_ceiling);

  // 25 mhz clock and a hang guard well above the expected run length
  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; entered right after an edge, leaves psel up for back-to-back use
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                     input logic s0);
    int n;
    logic hit;
    n = 0;
    hit = 1'b0;
    for (int i = 0; i < 23; i++) begin
      if ({2'b00, IDX[i], 2'b00} === a) begin
        hit = 1'b1;
        n = i;
      end
    end
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h5a5a5a, d};
    pstrb <= {3'h7, s0};
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed; only the bench timeout ends a wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    chk({pready, pslverr}, {1'b1, !hit});
    if (!wr) chk(prdata, hit ? {24'h0, mem[n]} : 32'h0);
    if (wr && hit && s0) mem[n] = (mem[n] & ~MSK[n]) | (d & MSK[n]);
    penable <= 1'b0;
  endtask

  task automatic idle(input int n);
    psel <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask

  // mode 0 reads every register, 1 writes all ones, 2 writes all zeros
  task automatic sweep(input int mode);
    for (int i = 0; i < 23; i++) begin
      apb(mode != 0, {2'b00, IDX[i], 2'b00}, mode == 1 ? 8'hff : 8'h00, 1'b1);
    end
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    chk({synth1_out0_drive, analog_out0_toggle, synth1_mult, feedback_trim_value}, 0);
    presetn <= 1'b1;
    for (int i = 0; i < 23; i++) mem[i] = RST[i];
  endtask

  // every field output against the decode of the expected image
  task automatic fields();
    chk(pulse_coarse_shift, mem[0][5:0]);
    chk(synth0_pulse1_rate_code, mem[1][2:0]);
    chk(pulse_clock_style, mem[2][0]);
    chk({pulse_polarity_select, pulse_edge_select}, {mem[2][7], mem[2][1]});
    chk(pulse_width_code, mem[2][6:4]);
    chk(pulse_width_from_clock, mem[2][6:4] == 3'h7);
    chk(synth1_power_on, mem[3][7]);
    chk({synth1_loop_select, analog_loop_select}, {mem[3][6], mem[8][6]});
    chk({synth1_out1_drive, synth1_out0_drive}, mem[3][1:0] & {2{mem[3][7]}});
    chk({synth1_out1_toggle, synth1_out0_toggle}, mem[4][1:0] & {2{mem[3][7]}});
    chk(synth1_mult, {mem[6][5:0], mem[5]});
    chk(synth1_pow2_exponent, mem[7][5:0]);
    chk({analog_power_on, analog_out1_drive, analog_out0_drive},
        {mem[8][7], mem[8][1:0] & {2{mem[8][7]}}});
    chk({analog_out1_toggle, analog_out0_toggle}, mem[9][1:0] & {2{mem[8][7]}});
    chk({out1_speed_group, out0_speed_group}, mem[9][5:4]);
    chk(analog_ethernet_family, mem[9][6]);
    chk({analog_out1_freq_code, analog_out0_freq_code}, mem[10]);
    chk(feedback_trim_value, mem[11]);
    chk(ext_page_select, mem[12]);
    chk(reference_rate_mode, {mem[14], mem[13]});
    chk(custom_a_rate, {mem[16][5:0], mem[15]});
    chk({custom_a_cycle_ceiling, custom_a_cycle_floor}, {mem[18], mem[17]});
    chk({custom_a_freq_ceiling, custom_a_freq_floor}, {mem[22], mem[21], mem[20], mem[19]});
  endtask

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    do_reset();
    idle(2);
    fields();
    sweep(0);
    $display("test reset values done");
    sweep(1);
    sweep(0);
    idle(2);
    fields();
    sweep(2);
    sweep(0);
    idle(2);
    fields();
    $display("test reserved bits done");
    // every rate, width, mode and low page code, with gating bits varied
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, 12'h10c, 8'(c), 1'b1);
      apb(1'b1, 12'h110, {c[0], 3'(c), 2'b11, c[1], c[2]}, 1'b1);
      apb(1'b1, 12'h120, {c[0], c[1], 4'hf, c[2], ~c[0]}, 1'b1);
      apb(1'b1, 12'h124, {6'h3f, c[1], c[2]}, 1'b1);
      apb(1'b1, 12'h140, {c[2], c[0], 4'hf, c[1], ~c[1]}, 1'b1);
      apb(1'b1, 12'h144, {1'b1, 3'(c), 2'b11, c[0], c[1]}, 1'b1);
      apb(1'b1, 12'h190, 8'(c), 1'b1);
      apb(1'b1, 12'h194, {4{c[1:0]}}, 1'b1);
      apb(1'b1, 12'h198, {4{~c[1:0]}}, 1'b1);
      apb(1'b1, 12'h18c, 8'h80 + 8'(c), 1'b1);
      idle(2);
      fields();
    end
    $display("test field codes done");
    apb(1'b1, 12'h114, 8'hff, 1'b1);
    apb(1'b0, 12'h1bc, 8'h00, 1'b1);
    apb(1'b1, 12'h10d, 8'h00, 1'b1);
    apb(1'b1, 12'h18c, 8'h00, 1'b0);
    sweep(0);
    $display("test refused accesses done");
    apb(1'b1, 12'h18c, 8'h12, 1'b1);
    idle(1);
    do_reset();
    idle(2);
    fields();
    sweep(0);
    $display("test second reset done");
    conclude();
  end
endmodule
`default_nettype wire
